//--- rtl/pmw_pkg.sv
// Package: constants for the page-mode wait-state and address multiplexer block
package pmw_pkg;
   // =====================================================
   // Wait-state counts
   localparam logic [2:0] PMW_WS_0 = 3'h0;
   localparam logic [2:0] PMW_WS_1 = 3'h1;
   localparam logic [2:0] PMW_WS_2 = 3'h2;
   localparam logic [2:0] PMW_WS_3 = 3'h3;
   localparam logic [2:0] PMW_WS_4 = 3'h4;
   // =====================================================
   // Address multiplexer configurations
   typedef enum logic [2:0] {
      PMW_CFG_PG_64K   = 3'h0, // 64K non-interleave / 2-way
      PMW_CFG_PG_1M    = 3'h1, // 64K 4-way, 256K 2-way, 1M non
      PMW_CFG_PG_4M    = 3'h2, // 256K 4-way, 1M 2-way, 4M non
      PMW_CFG_PG_1M4W  = 3'h3, // 1M 4-way, 4M 2-way
      PMW_CFG_PG_4M4W  = 3'h4, // 4M 4-way
      PMW_CFG_NP2_1M   = 3'h5, // non-page 2-way, 1M
      PMW_CFG_NP2_4M   = 3'h6, // non-page 2-way, 4M
      PMW_CFG_NP2_256K = 3'h7  // non-page 2-way, 256K
   } pmw_cfg_t;
   // =====================================================
   // Cycle controller states (one-hot)
   typedef enum logic [3:0] {
      PMW_IDLE  = 4'h1,
      PMW_ROW   = 4'h2,
      PMW_WAIT  = 4'h4,
      PMW_DONE  = 4'h8
   } pmw_state_t;
endpackage : pmw_pkg

//--- rtl/pmw_if.sv
// Interface: wait-state selector request and answer
`timescale 1ns/1ps
interface pmw_if;
   import pmw_pkg::*;
   logic       cpu_mode2;
   logic       pipelined;
   logic       cache_present;
   logic       cache_hit;
   logic       write;
   logic       page_hit;
   logic       first_access;
   logic       raw;
   logic [2:0] wait_states;
   modport sel (input cpu_mode2, pipelined, cache_present, cache_hit, write, page_hit,
                first_access, raw, output wait_states);
   modport ctl (output cpu_mode2, pipelined, cache_present, cache_hit, write, page_hit,
                first_access, raw, input wait_states);
endinterface : pmw_if

//--- rtl/pmw_ws_select.sv
// Wait-state selector for page-mode DRAM cycles
`timescale 1ns/1ps
module pmw_ws_select
   import pmw_pkg::*;
(
   pmw_if.sel  ws
);
   always_comb begin
      ws.wait_states = PMW_WS_0;
      if (ws.write) begin
         if (ws.page_hit) begin
            // Second mode without cache, non-pipelined write hit costs one
            if (ws.cpu_mode2 && !ws.cache_present && !ws.pipelined) begin
               ws.wait_states = PMW_WS_1;
            end else begin
               ws.wait_states = PMW_WS_0;
            end
         end else if (ws.first_access) begin
            ws.wait_states = PMW_WS_1;
         end else if (ws.cpu_mode2 && !ws.cache_present && !ws.pipelined) begin
            ws.wait_states = PMW_WS_3;
         end else begin
            ws.wait_states = PMW_WS_2;
         end
      end else if (ws.cache_present) begin
         if (ws.cache_hit) begin
            ws.wait_states = PMW_WS_0;
         end else if (ws.page_hit) begin
            ws.wait_states = PMW_WS_1;
         end else if (ws.first_access) begin
            ws.wait_states = PMW_WS_3;
         end else begin
            ws.wait_states = PMW_WS_4;
         end
      end else if (!ws.cpu_mode2) begin
         if (ws.page_hit) begin
            ws.wait_states = ws.raw ? PMW_WS_1 : PMW_WS_0;
         end else if (ws.first_access) begin
            ws.wait_states = PMW_WS_2;
         end else begin
            ws.wait_states = PMW_WS_3;
         end
      end else if (ws.pipelined) begin
         if (ws.page_hit) begin
            ws.wait_states = ws.raw ? PMW_WS_1 : PMW_WS_0;
         end else if (ws.first_access) begin
            ws.wait_states = PMW_WS_2;
         end else begin
            ws.wait_states = PMW_WS_3;
         end
      end else begin
         if (ws.page_hit) begin
            ws.wait_states = PMW_WS_1;
         end else if (ws.first_access) begin
            ws.wait_states = PMW_WS_3;
         end else begin
            ws.wait_states = PMW_WS_4;
         end
      end
   end
endmodule : pmw_ws_select

//--- rtl/pmw_ctrl.sv
// Top: page-mode DRAM wait-state controller and address multiplexer
// Function
// - After refresh, DMA or master: first access
// - First access skips precharge, one less wait (two less on no-cache non-pipe mode two writes)
// - First access needs equal banks, non-EMS
// - Writes: hit 0, first 1, miss 2
// - Mode one reads: hit 0, first 2, miss 3
// - Mode one read-after-write hit: 1 wait
// - Cache: hit 0, then 1/3/4 on miss
// - Mode two non-pipe read miss 4, first 3
// - Mode two no-cache write hit: pipe 0, else 1; non-pipe miss 3
// - Mux drives row then column, all sizes
// - Page column A11..A1; 4M 4-way row map
// - Non-page 2-way row and 4M column map
`timescale 1ns/1ps
module pmw_ctrl
   import pmw_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        clock_en,
   input  wire logic        cyc_start,
   input  wire logic        cyc_write,
   input  wire logic [24:1] cpu_addr,
   input  wire logic        cpu_mode2,
   input  wire logic        pipelined,
   input  wire logic        cache_present,
   input  wire logic        cache_hit,
   input  wire logic        page_hit,
   input  wire logic        prev_refresh,
   input  wire logic        prev_dma,
   input  wire logic        prev_master,
   input  wire logic        banks_equal,
   input  wire logic        ems_cycle,
   input  wire logic        refresh_cycle,
   input  wire logic [10:0] refresh_count,
   input  wire pmw_cfg_t    addr_cfg,
   output logic      [10:0] mem_addr,
   output logic             col_phase,
   output logic             cpu_ready,
   output logic             busy
);
   // =====================================================
   // Cycle classification
   pmw_if       ws_bus();
   pmw_state_t  state;
   pmw_state_t  next_state;
   logic [2:0]  count;
   logic [2:0]  next_count;
   logic        last_write;
   logic        next_last_write;
   logic [10:0] next_mem_addr;
   logic        next_col_phase;
   logic        first_acc;

   assign first_acc = (prev_refresh || prev_dma || prev_master)
                      && banks_equal && !ems_cycle;
   assign ws_bus.cpu_mode2     = cpu_mode2;
   assign ws_bus.pipelined     = pipelined;
   assign ws_bus.cache_present = cache_present;
   assign ws_bus.cache_hit     = cache_hit;
   assign ws_bus.write         = cyc_write;
   assign ws_bus.page_hit      = page_hit;
   assign ws_bus.first_access  = first_acc;
   assign ws_bus.raw           = last_write && !cyc_write;

   pmw_ws_select u_sel (
      .ws (ws_bus)
   );

   // =====================================================
   // Address multiplexer
   function automatic logic [10:0] row_map(input pmw_cfg_t c, input logic [24:1] a);
      logic [10:0] r;
      r = {a[22], a[20], a[18], a[16], a[15], a[14], a[13], a[12], a[11], a[10], a[1]};
      unique case (c)
         PMW_CFG_PG_1M:   r[1:0] = {a[19], a[17]};
         PMW_CFG_PG_4M:   r[2:0] = {a[21], a[19], a[17]};
         PMW_CFG_PG_1M4W: r[3:0] = {a[23], a[21], a[19], a[17]};
         PMW_CFG_PG_4M4W: r[4:0] = {a[24], a[23], a[21], a[19], a[17]};
         PMW_CFG_NP2_1M, PMW_CFG_NP2_4M, PMW_CFG_NP2_256K:
            r = {a[11:2], a[13]};
         default: r = r;
      endcase
      return r;
   endfunction : row_map

   function automatic logic [10:0] col_map(input pmw_cfg_t c, input logic [24:1] a);
      logic [10:0] r;
      r = {a[11:2], a[1]};
      unique case (c)
         PMW_CFG_NP2_256K:
            r = {a[22], a[20], a[18], a[16], a[15], a[14], a[19], a[12], a[11], a[10], a[17]};
         PMW_CFG_NP2_1M:
            r = {a[22], a[20], a[18], a[16], a[15], a[14], a[21], a[12], a[11], a[19], a[17]};
         PMW_CFG_NP2_4M:
            r = {a[22], a[20], a[18], a[16], a[15], a[14], a[12], a[23], a[21], a[19],
                 a[17]};
         default: r = r;
      endcase
      return r;
   endfunction : col_map

   // =====================================================
   // Cycle sequencer
   always_comb begin
      next_state      = state;
      next_count      = count;
      next_last_write = last_write;
      next_mem_addr   = mem_addr;
      next_col_phase  = col_phase;
      unique case (state)
         PMW_IDLE: begin
            if (refresh_cycle) begin
               next_mem_addr   = refresh_count;
               next_col_phase  = 1'b0;
               next_last_write = 1'b0;
            end else if (cyc_start) begin
               next_mem_addr   = row_map(addr_cfg, cpu_addr);
               next_col_phase  = 1'b0;
               next_count      = ws_bus.wait_states;
               next_last_write = cyc_write;
               next_state      = PMW_ROW;
            end
         end
         PMW_ROW: begin
            next_mem_addr  = col_map(addr_cfg, cpu_addr);
            next_col_phase = 1'b1;
            next_state     = (count == PMW_WS_0) ? PMW_DONE : PMW_WAIT;
         end
         PMW_WAIT: begin
            next_count = count - PMW_WS_1;
            if (count == PMW_WS_1) begin
               next_state = PMW_DONE;
            end
         end
         PMW_DONE: next_state = PMW_IDLE;
         default: next_state = PMW_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state      <= PMW_IDLE;
         count      <= PMW_WS_0;
         last_write <= 1'b0;
         mem_addr   <= 11'h000;
         col_phase  <= 1'b0;
      end else if (clock_en) begin
         state      <= next_state;
         count      <= next_count;
         last_write <= next_last_write;
         mem_addr   <= next_mem_addr;
         col_phase  <= next_col_phase;
      end
   end

   // Ready is a one-cycle pulse after the wait states elapse
   assign cpu_ready = (state == PMW_DONE);
   assign busy      = (state != PMW_IDLE);

   // =====================================================
   // Checks
   a_ready_after_row: assert property (@(posedge clock) disable iff (!rstn)
      (clock_en && state == PMW_ROW && count == PMW_WS_0) |=> cpu_ready)
      else $error("ready not given after zero-wait cycle");
   a_wait_no_ready: assert property (@(posedge clock) disable iff (!rstn)
      (clock_en && state == PMW_WAIT && count != PMW_WS_1) |=> !cpu_ready)
      else $error("ready during wait states");
   a_col_after_row: assert property (@(posedge clock) disable iff (!rstn)
      (clock_en && state == PMW_ROW) |=> col_phase)
      else $error("column phase missing");
   a_refresh_addr: assert property (@(posedge clock) disable iff (!rstn)
      (clock_en && state == PMW_IDLE && refresh_cycle) |=> mem_addr == $past(refresh_count))
      else $error("refresh address wrong");
   a_first_gate: assert property (@(posedge clock) disable iff (!rstn)
      (ems_cycle || !banks_equal) |-> !ws_bus.first_access)
      else $error("first access in illegal config");
   a_write_miss: assert property (@(posedge clock) disable iff (!rstn)
      (cyc_write && !page_hit && !first_acc && !cpu_mode2) |-> ws_bus.wait_states == 3'h2)
      else $error("write miss wait count wrong");
   a_cache_hit_zero: assert property (@(posedge clock) disable iff (!rstn)
      (!cyc_write && cache_present && cache_hit) |-> ws_bus.wait_states == 3'h0)
      else $error("cache hit not zero wait");
   a_m2_read_miss: assert property (@(posedge clock) disable iff (!rstn)
      (cpu_mode2 && !pipelined && !cache_present && !cyc_write && !page_hit)
      |-> ws_bus.wait_states == (first_acc ? 3'h3 : 3'h4))
      else $error("mode two read miss wait wrong");
   a_m2_write_hit: assert property (@(posedge clock) disable iff (!rstn)
      (cpu_mode2 && !cache_present && cyc_write && page_hit)
      |-> ws_bus.wait_states == (pipelined ? 3'h0 : 3'h1))
      else $error("mode two write hit wait wrong");
endmodule : pmw_ctrl

//--- verif/pmw_dram_model.sv
// Partner model: DRAM bank that captures the strobed row and column addresses
`timescale 1ns/1ps
module pmw_dram_model (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        busy,
   input  wire logic        col_phase,
   input  wire logic [10:0] mem_addr,
   output logic      [10:0] row_seen,
   output logic      [10:0] col_seen
);
   // =====================================================
   // Strobe capture
   // Captures on the edge after the phase shows, as a bank would on its strobe
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         row_seen <= 11'h000;
         col_seen <= 11'h000;
      end else if (busy && !col_phase) begin
         row_seen <= mem_addr;
      end else if (busy && col_phase) begin
         col_seen <= mem_addr;
      end
   end
endmodule : pmw_dram_model

//--- verif/pmw_ctrl_tb_top.sv
// Testbench: wait-state selection and address multiplexing of pmw_ctrl
`timescale 1ns/1ps
module pmw_ctrl_tb_top;
   import pmw_pkg::*;
   // Edges after the take edge until ready shows, with no waits
   localparam int BASE = 1;
   logic        clock, rstn, cyc_start, cyc_write, cpu_mode2, pipelined;
   logic        cache_present, cache_hit, page_hit, prev_refresh, prev_dma, prev_master;
   logic        banks_equal, ems_cycle, refresh_cycle, col_phase, cpu_ready, busy;
   logic [24:1] cpu_addr;
   logic [10:0] refresh_count, mem_addr, row_seen, col_seen;
   pmw_cfg_t    addr_cfg;
   int          mismatches, tests_run;

   pmw_ctrl DUT (.clock(clock), .rstn(rstn), .clock_en(1'b1), .cyc_start(cyc_start),
      .cyc_write(cyc_write), .cpu_addr(cpu_addr), .cpu_mode2(cpu_mode2), .pipelined(pipelined),
      .cache_present(cache_present), .cache_hit(cache_hit), .page_hit(page_hit),
      .prev_refresh(prev_refresh), .prev_dma(prev_dma), .prev_master(prev_master),
      .banks_equal(banks_equal), .ems_cycle(ems_cycle), .refresh_cycle(refresh_cycle),
      .refresh_count(refresh_count), .addr_cfg(addr_cfg), .mem_addr(mem_addr),
      .col_phase(col_phase), .cpu_ready(cpu_ready), .busy(busy));
   pmw_dram_model mem (.clock(clock), .rstn(rstn), .busy(busy), .col_phase(col_phase),
      .mem_addr(mem_addr), .row_seen(row_seen), .col_seen(col_seen));

   // =====================================================
   // Shared tasks
   task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // src: 0 none, 1 refresh, 2 DMA, 3 bus master before this cycle
   task automatic run(input logic m2, pp, cp, ch, wr, ph, input int src, w);
      int k;
      logic [24:1] a;
      logic [10:0] er;
      logic [10:0] ec;
      @(posedge clock);
      // Taken after the edge so an address set on the previous edge is seen
      a = cpu_addr;
      cyc_start <= 1'b1;
      cyc_write <= wr;
      cpu_mode2 <= m2;
      pipelined <= pp;
      cache_present <= cp;
      cache_hit <= ch;
      page_hit <= ph;
      prev_refresh <= (src == 1);
      prev_dma <= (src == 2);
      prev_master <= (src == 3);
      @(posedge clock);
      cyc_start <= 1'b0;
      k = 0;
      do begin
         @(posedge clock);
         #1;
         k++;
      end while (cpu_ready !== 1'b1 && k < 20);
      check("ready delay", 11'(k), 11'(BASE + w));
      check("column phase", {10'h000, col_phase}, 11'h001);
      @(posedge clock);
      #1;
      check("idle after ready", {10'h000, busy}, 11'h000);
      // Bank latches the column one edge after it shows, so compare only now
      er = {a[22], a[20], a[18], a[16], a[15], a[14], a[13], a[12], a[11], a[10], a[1]};
      ec = a[11:1];
      case (addr_cfg)
         PMW_CFG_PG_1M:   er[1:0] = {a[19], a[17]};
         PMW_CFG_PG_4M:   er[2:0] = {a[21], a[19], a[17]};
         PMW_CFG_PG_1M4W: er[3:0] = {a[23], a[21], a[19], a[17]};
         PMW_CFG_PG_4M4W: er[4:0] = {a[24], a[23], a[21], a[19], a[17]};
         PMW_CFG_NP2_256K: begin
            er = {a[11:2], a[13]};
            ec = {a[22], a[20], a[18], a[16], a[15], a[14], a[19], a[12], a[11], a[10], a[17]};
         end
         PMW_CFG_NP2_1M: begin
            er = {a[11:2], a[13]};
            ec = {a[22], a[20], a[18], a[16], a[15], a[14], a[21], a[12], a[11], a[19], a[17]};
         end
         PMW_CFG_NP2_4M: begin
            er = {a[11:2], a[13]};
            ec = {a[22], a[20], a[18], a[16], a[15], a[14], a[12], a[23], a[21], a[19], a[17]};
         end
         default: begin
         end
      endcase
      check("row", row_seen, er);
      check("column", col_seen, ec);
   endtask : run

   // =====================================================
   // Scenarios
   task automatic t_writes;
      run(0, 0, 0, 0, 1, 1, 0, 0);
      run(0, 0, 0, 0, 1, 0, 1, 1);
      run(0, 0, 0, 0, 1, 0, 0, 2);
      run(0, 0, 1, 0, 1, 0, 2, 1);
      run(0, 0, 1, 0, 1, 0, 0, 2);
      run(1, 0, 1, 0, 1, 1, 0, 0);
      $display("writes done");
   endtask : t_writes

   task automatic t_reads;
      run(0, 0, 0, 0, 0, 1, 0, 1);
      run(0, 0, 0, 0, 0, 1, 0, 0);
      run(0, 0, 0, 0, 0, 0, 3, 2);
      run(0, 0, 0, 0, 0, 0, 0, 3);
      run(0, 0, 1, 1, 0, 0, 0, 0);
      run(0, 0, 1, 0, 0, 1, 0, 1);
      run(0, 0, 1, 0, 0, 0, 2, 3);
      run(1, 0, 1, 0, 0, 0, 0, 4);
      run(1, 0, 1, 1, 0, 1, 0, 0);
      $display("reads done");
   endtask : t_reads

   task automatic t_gate;
      banks_equal <= 1'b0;
      run(0, 0, 0, 0, 0, 0, 1, 3);
      banks_equal <= 1'b1;
      ems_cycle <= 1'b1;
      run(0, 0, 0, 0, 0, 0, 1, 3);
      ems_cycle <= 1'b0;
      $display("first access gate done");
   endtask : t_gate

   task automatic t_mode2;
      run(1, 0, 0, 0, 0, 0, 0, 4);
      run(1, 0, 0, 0, 0, 0, 3, 3);
      run(1, 1, 0, 0, 1, 1, 0, 0);
      run(1, 0, 0, 0, 1, 1, 0, 1);
      $display("mode two done");
   endtask : t_mode2

   // Every socket configuration, each with an address and its complement
   task automatic t_addr;
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 2; j++) begin
            @(posedge clock);
            addr_cfg <= pmw_cfg_t'(3'(i));
            cpu_addr <= (j == 0) ? 24'h4A5C39 : 24'hB5A3C6;
            run(0, 0, 0, 0, 1, 1, 0, 0);
         end
      end
      $display("address mux done");
   endtask : t_addr

   task automatic t_refresh;
      // Start held high too: refresh must win and the cycle stay refused
      @(posedge clock);
      refresh_cycle <= 1'b1;
      refresh_count <= 11'h5A3;
      cyc_start <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check("refresh row", mem_addr, 11'h5A3);
      check("start refused", {10'h000, busy}, 11'h000);
      @(posedge clock);
      refresh_count <= 11'h25C;
      repeat (2) @(posedge clock);
      #1;
      check("refresh row", mem_addr, 11'h25C);
      @(posedge clock);
      refresh_cycle <= 1'b0;
      cyc_start <= 1'b0;
      $display("refresh done");
   endtask : t_refresh

   task automatic close_out;
      $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   // =====================================================
   // Clock, reset, sequence and watchdog
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial begin
      {rstn, cyc_start, cyc_write, cpu_mode2, pipelined, cache_present, cache_hit} = '0;
      {page_hit, prev_refresh, prev_dma, prev_master, ems_cycle, refresh_cycle} = '0;
      banks_equal = 1'b1;
      refresh_count = 11'h000;
      cpu_addr = 24'hB5A3C6;
      addr_cfg = PMW_CFG_PG_4M4W;
      mismatches = 0;
      tests_run = 0;
      repeat (5) @(posedge clock);
      #1;
      check("reset outputs", {8'h00, cpu_ready, busy, col_phase}, 11'h000);
      check("reset address", mem_addr, 11'h000);
      @(posedge clock);
      rstn <= 1'b1;
      t_writes();
      t_reads();
      t_gate();
      t_mode2();
      t_addr();
      t_refresh();
      close_out();
   end

   initial begin
      #20000;
      mismatches++;
      close_out();
   end
endmodule : pmw_ctrl_tb_top
